// ### hw/bia_pkg.sv
// Purpose: shared constants and types for the interrupt acknowledge cycle
// Assumes: 100 MHz local clock; all bus lines active low, pulled up when idle
// Notes: each time is kept in ns, and its cycle count is derived from it
package bia_pkg;
   // local clock period
   localparam int CLK_NS = 10;
   // least as high time before own as goes low
   localparam int T_GAP_NS = 30;
   // iack, code and lword valid before as falls
   localparam int T_SETUP_NS = 35;
   // both strobes high before the first strobe falls
   localparam int T_DSHI_NS = 40;
   // write high before the first strobe falls
   localparam int T_WRHI_NS = 40;
   // longest gap from first to second strobe
   localparam int T_DSB_MAX_NS = 20;
   // least as low time
   localparam int T_ASLO_NS = 40;
   // write kept high after both strobes rise
   localparam int T_WRHOLD_NS = 10;
   // longest drive of as high before release
   localparam int T_ASREL_MAX_NS = 30;
   // least wait after first strobe before dtack or berr
   localparam int T_ACKWAIT_NS = 30;
   // least times round up, longest times round down, floor of one cycle
   localparam int C_GAP = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_SETUP = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_DSHI = (T_DSHI_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_WRHI = (T_WRHI_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_ASLO = (T_ASLO_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_WRHOLD = (T_WRHOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_ACKWAIT = (T_ACKWAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_DSB_MAX = (T_DSB_MAX_NS / CLK_NS < 1) ? 1 : T_DSB_MAX_NS / CLK_NS;
   localparam int C_ASREL_MAX = (T_ASREL_MAX_NS / CLK_NS < 1) ? 1 : T_ASREL_MAX_NS / CLK_NS;
   // bit positions in the handler control vector
   localparam int CTL_W = 9;
   localparam int CTL_AS = 0;
   localparam int CTL_DS0 = 1;
   localparam int CTL_DS1 = 2;
   localparam int CTL_WR = 3;
   localparam int CTL_IACK = 4;
   localparam int CTL_LW = 5;
   localparam int CTL_A1 = 6;
   // width of the status id bus
   localparam int DATA_W = 32;
   // width of the acknowledge code
   localparam int CODE_W = 3;
   // transfer width of the status id
   typedef enum logic [1:0] {
      BIA_SZ_SINGLE = 2'h0,
      BIA_SZ_DOUBLE = 2'h1,
      BIA_SZ_QUAD = 2'h2
   } bia_size_t;
endpackage : bia_pkg

// ### hw/bia_if.sv
// Purpose: backplane wires between the handler and one interrupter
// Assumes: idle lines are pulled high; output enables are active low
// Notes: the interrupter sits in slot one, so its iackin is the iack line
`timescale 1ns/1ps
interface bia_if;
   import bia_pkg::*;
   // handler control lines: as, ds0, ds1, write, iack, lword, a01-a03
   logic [CTL_W-1:0] h_ctl_o;
   logic [CTL_W-1:0] h_ctl_oe_n;
   logic [CTL_W-1:0] ctl;
   // interrupter answer lines
   logic i_dtack_o;
   logic i_dtack_oe_n;
   logic i_berr_o;
   logic i_berr_oe_n;
   logic [DATA_W-1:0] i_d_o;
   logic i_d_oe_n;
   logic iackout_n;
   // resolved levels
   logic dtack_n;
   logic berr_n;
   logic [DATA_W-1:0] d;
   // undriven bits float high through the pull-ups
   assign ctl = h_ctl_oe_n | h_ctl_o;
   assign dtack_n = i_dtack_oe_n | i_dtack_o;
   assign berr_n = i_berr_oe_n | i_berr_o;
   assign d = i_d_oe_n ? {DATA_W{1'b1}} : i_d_o;
   // the acknowledging end
   modport handler (
      output h_ctl_o, h_ctl_oe_n,
      input ctl, dtack_n, berr_n, d
   );
   // the answering end
   modport interrupter (
      output i_dtack_o, i_dtack_oe_n, i_berr_o, i_berr_oe_n, i_d_o, i_d_oe_n, iackout_n,
      input ctl
   );
endinterface : bia_if

// ### hw/bia_sync.sv
// Purpose: two-stage synchroniser for backplane inputs
// Assumes: idle level of every input is high
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module bia_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // raw and synchronised levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta; // first stage, read only by q

   // both stages reset to the idle high level
   always_ff @(posedge clock) begin
      if (reset) begin
         meta <= {W{1'b1}};
         q <= {W{1'b1}};
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : bia_sync

// ### hw/bia_handler.sv
// Purpose: interrupt handler end of the acknowledge cycle
// Assumes: the requester grants the bus outside this block
// Notes: as, dtack and berr pass a two-stage synchroniser before use; the data lines are sampled directly
`timescale 1ns/1ps
module bia_handler
   import bia_pkg::*;
#(
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // requester side
   output logic wants_bus,
   input wire logic bus_granted,
   // user request
   input wire logic start,
   input wire logic [CODE_W-1:0] level,
   input wire bia_size_t size,
   // user answer
   output logic busy,
   output logic done,
   output logic bus_error,
   output logic [DATA_W-1:0] status_id,
   // backplane
   bia_if.handler bus
);
   // refuse counts that do not fit the counters
   initial begin
      if (CNT_W < 4 || (1 << CNT_W) <= C_DSHI + C_WRHI + C_SETUP + C_ASLO + C_GAP) begin
         $error("bia_handler: CNT_W too small for the timing counts");
      end
   end

   // handler states, one-hot
   typedef enum logic [9:0] {
      H_IDLE = 10'h001,
      H_REQ = 10'h002,
      H_SETUP = 10'h004,
      H_AS = 10'h008,
      H_DSA = 10'h010,
      H_ACK = 10'h020,
      H_STRB_UP = 10'h040,
      H_WR_HOLD = 10'h080,
      H_REL = 10'h100,
      H_AS_UP = 10'h200
   } bia_hstate_t;

   bia_hstate_t state; // current state
   bia_hstate_t next_state; // next state
   logic [2:0] sync_q; // synced as, dtack, berr
   logic as_s; // synced as level
   logic dtack_s; // synced dtack level
   logic berr_s; // synced berr level
   logic answered; // dtack or berr seen low
   logic [CNT_W-1:0] as_hi_cnt; // cycles the bus as has been high
   logic [CNT_W-1:0] run_cnt; // cycles since lines were driven
   logic [CNT_W-1:0] as_lo_cnt; // cycles since own as fell
   logic [CNT_W-1:0] hold_cnt; // cycles since strobes rose
   logic [CODE_W-1:0] lvl_q; // latched acknowledge code
   bia_size_t size_q; // latched transfer width

   // saturating increment for the counters
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
   endfunction : sat_inc

   bia_sync #(.W(3)) u_sync (
      .clock(clock),
      .reset(reset),
      .d({bus.berr_n, bus.dtack_n, bus.ctl[CTL_AS]}),
      .q(sync_q)
   );
   assign as_s = sync_q[0];
   assign dtack_s = sync_q[1];
   assign berr_s = sync_q[2];
   assign answered = !dtack_s || !berr_s;

   // state register
   always_ff @(posedge clock) begin
      if (reset) begin
         state <= H_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // next state
   always_comb begin
      next_state = state;
      unique case (state)
         // waiting for a user request
         H_IDLE: begin
            if (start) begin
               next_state = H_REQ;
            end
         end
         // granted and previous owner let as rise
         // as idle long enough, also serves
         H_REQ: begin
            if (bus_granted && as_s && as_hi_cnt >= CNT_W'(C_GAP)) begin
               next_state = H_SETUP;
            end
         end
         H_SETUP: begin
            if (run_cnt >= CNT_W'(C_SETUP)) begin
               next_state = H_AS;
            end
         end
         // ack lines high, strobes and write high long enough
         H_AS: begin
            if (dtack_s && berr_s && run_cnt >= CNT_W'(C_DSHI)
                && run_cnt >= CNT_W'(C_WRHI)) begin
               next_state = H_DSA;
            end
         end
         // first strobe low for one cycle before the second
         H_DSA: begin
            next_state = H_ACK;
         end
         // as low until answer and least time
         H_ACK: begin
            if (answered && as_lo_cnt >= CNT_W'(C_ASLO)) begin
               next_state = H_STRB_UP;
            end
         end
         // strobes driven high
         H_STRB_UP: begin
            next_state = H_WR_HOLD;
         end
         // write stays high after strobes rise
         H_WR_HOLD: begin
            if (hold_cnt >= CNT_W'(C_WRHOLD)) begin
               next_state = H_REL;
            end
         end
         // lines released while as still low
         H_REL: begin
            next_state = H_AS_UP;
         end
         // as driven high one cycle, then released
         H_AS_UP: begin
            next_state = start ? H_REQ : H_IDLE;
         end
         default: begin
            next_state = H_IDLE;
         end
      endcase
   end

   // count of continuous as high on the bus
   always_ff @(posedge clock) begin
      if (reset) begin
         as_hi_cnt <= '0;
      end else if (!as_s) begin
         as_hi_cnt <= '0;
      end else begin
         as_hi_cnt <= sat_inc(as_hi_cnt);
      end
   end

   // cycles since iack, strobes and write were first driven
   always_ff @(posedge clock) begin
      if (reset) begin
         run_cnt <= '0;
      end else if (state == H_SETUP || state == H_AS) begin
         run_cnt <= sat_inc(run_cnt);
      end else begin
         run_cnt <= CNT_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         as_lo_cnt <= '0;
      end else if (state == H_DSA || state == H_ACK) begin
         as_lo_cnt <= sat_inc(as_lo_cnt);
      end else if (state == H_AS) begin
         as_lo_cnt <= CNT_W'(1);
      end else begin
         as_lo_cnt <= '0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         hold_cnt <= '0;
      end else if (state == H_WR_HOLD) begin
         hold_cnt <= sat_inc(hold_cnt);
      end else begin
         hold_cnt <= CNT_W'(1);
      end
   end

   // request latched when the cycle begins
   always_ff @(posedge clock) begin
      if (reset) begin
         lvl_q <= '0;
         size_q <= BIA_SZ_SINGLE;
      end else if (state == H_IDLE || state == H_AS_UP) begin
         lvl_q <= level;
         size_q <= size;
      end
   end

   // answer capture; data has passed two sync cycles of settling
   always_ff @(posedge clock) begin
      if (reset) begin
         status_id <= '0;
         bus_error <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (state == H_ACK && next_state == H_STRB_UP) begin
            status_id <= bus.d;
            bus_error <= !berr_s;
            done <= 1'b1;
         end
      end
   end

   // wants the bus until lines and as are released
   always_ff @(posedge clock) begin
      if (reset) begin
         wants_bus <= 1'b0;
      end else if (state == H_IDLE) begin
         wants_bus <= start;
      end else if (state == H_AS_UP) begin
         wants_bus <= start;
      end
   end

   assign busy = (state != H_IDLE);

   // control line levels and enables
   always_comb begin
      bus.h_ctl_o = '1;
      bus.h_ctl_oe_n = '1;
      // code, lword and iack held from setup until release
      if (state inside {H_SETUP, H_AS, H_DSA, H_ACK, H_STRB_UP, H_WR_HOLD}) begin
         bus.h_ctl_oe_n = '0;
         bus.h_ctl_o[CTL_IACK] = 1'b0;
         bus.h_ctl_o[CTL_LW] = (size_q != BIA_SZ_QUAD);
         bus.h_ctl_o[CTL_A1 +: CODE_W] = lvl_q;
      end
      // as low from as state until release is done
      if (state inside {H_AS, H_DSA, H_ACK, H_STRB_UP, H_WR_HOLD, H_REL}) begin
         bus.h_ctl_oe_n[CTL_AS] = 1'b0;
         bus.h_ctl_o[CTL_AS] = 1'b0;
      end
      // first strobe low until answer seen
      if (state == H_DSA || state == H_ACK) begin
         bus.h_ctl_o[CTL_DS0] = 1'b0;
      end
      // second strobe one cycle after the first when wider
      if (state == H_ACK && size_q != BIA_SZ_SINGLE) begin
         bus.h_ctl_o[CTL_DS1] = 1'b0;
      end
      // as driven high one cycle before release
      if (state == H_AS_UP) begin
         bus.h_ctl_oe_n[CTL_AS] = 1'b0;
      end
   end
endmodule : bia_handler

// ### hw/bia_interrupter.sv
// Purpose: interrupter end of the acknowledge cycle, slot one
// Assumes: iackin is the iack line; the handler keeps its timing
// Notes: answers when the code on a01-a03 matches its pending level
`timescale 1ns/1ps
module bia_interrupter
   import bia_pkg::*;
#(
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // user side
   input wire logic [CODE_W-1:0] irq_level,
   input wire logic [DATA_W-1:0] status_id,
   input wire logic answer_berr,
   output logic ack_taken,
   output bia_size_t ack_size,
   // backplane
   bia_if.interrupter bus
);
   // refuse counts that do not fit the counter
   initial begin
      if ((1 << CNT_W) <= C_ACKWAIT + C_DSB_MAX + 1) begin
         $error("bia_interrupter: CNT_W too small for the timing counts");
      end
   end

   // interrupter states, one-hot
   typedef enum logic [5:0] {
      I_IDLE = 6'h01,
      I_SIZE = 6'h02,
      I_DRIVE = 6'h04,
      I_ACK = 6'h08,
      I_DREL = 6'h10,
      I_PASS = 6'h20
   } bia_istate_t;

   bia_istate_t state; // current state
   logic [CTL_W-1:0] ctl_s; // synced control lines
   logic ds0_d; // previous synced first strobe
   logic dsa_fall; // first strobe just fell
   logic [CNT_W-1:0] cnt; // cycles since first strobe fell
   logic dsb_seen; // second strobe fell within the window
   logic [DATA_W-1:0] d_q; // held status id
   logic berr_q; // answer kind chosen for this cycle, steady to the end

   bia_sync #(.W(CTL_W)) u_sync (
      .clock(clock),
      .reset(reset),
      .d(bus.ctl),
      .q(ctl_s)
   );

   // edge of the first strobe, from the synced level
   always_ff @(posedge clock) begin
      if (reset) begin
         ds0_d <= 1'b1;
      end else begin
         ds0_d <= ctl_s[CTL_DS0];
      end
   end
   assign dsa_fall = ds0_d && !ctl_s[CTL_DS0];

   // state, counters and answer
   always_ff @(posedge clock) begin
      if (reset) begin
         state <= I_IDLE;
         cnt <= '0;
         dsb_seen <= 1'b0;
         ack_taken <= 1'b0;
         ack_size <= BIA_SZ_SINGLE;
         d_q <= '0;
         berr_q <= 1'b0;
      end else begin
         ack_taken <= 1'b0;
         unique case (state)
            // act only on strobe fall with iackin low
            I_IDLE: begin
               cnt <= '0;
               dsb_seen <= 1'b0;
               if (dsa_fall && !ctl_s[CTL_IACK] && !ctl_s[CTL_AS]) begin
                  if (irq_level != '0 && ctl_s[CTL_A1 +: CODE_W] == irq_level) begin
                     state <= I_SIZE;
                  end else begin
                     // pass on after iackin low, nothing driven
                     state <= I_PASS;
                  end
               end
            end
            I_SIZE: begin
               cnt <= cnt + CNT_W'(1);
               if (!ctl_s[CTL_DS1] && cnt <= CNT_W'(C_DSB_MAX)) begin
                  dsb_seen <= 1'b1;
               end
               if (cnt >= CNT_W'(C_ACKWAIT) && cnt > CNT_W'(C_DSB_MAX)) begin
                  state <= I_DRIVE;
                  // latch the answer kind so a late user change cannot swap it
                  berr_q <= answer_berr;
                  if (!dsb_seen) begin
                     ack_size <= BIA_SZ_SINGLE;
                     d_q <= {{(DATA_W-8){1'b1}}, status_id[7:0]};
                  end else if (!ctl_s[CTL_LW]) begin
                     ack_size <= BIA_SZ_QUAD;
                     d_q <= status_id;
                  end else begin
                     ack_size <= BIA_SZ_DOUBLE;
                     d_q <= {{(DATA_W-16){1'b1}}, status_id[15:0]};
                  end
               end
            end
            // data placed one cycle before dtack
            I_DRIVE: begin
               state <= I_ACK;
               ack_taken <= 1'b1;
            end
            // answer held until both strobes high
            I_ACK: begin
               if (ctl_s[CTL_DS0] && ctl_s[CTL_DS1]) begin
                  state <= I_DREL;
               end
            end
            // data released a cycle before the answer
            I_DREL: begin
               state <= I_IDLE;
            end
            // iackout back high once as rises
            I_PASS: begin
               if (ctl_s[CTL_AS]) begin
                  state <= I_IDLE;
               end
            end
            default: begin
               state <= I_IDLE;
            end
         endcase
      end
   end

   // iackout low only while passing on, iackin low
   always_ff @(posedge clock) begin
      if (reset) begin
         bus.iackout_n <= 1'b1;
      end else begin
         bus.iackout_n <= !(state == I_PASS && !ctl_s[CTL_IACK] && !ctl_s[CTL_AS]);
      end
   end

   // data held steady from drive until strobes rise
   assign bus.i_d_o = d_q;
   assign bus.i_d_oe_n = !((state == I_DRIVE || state == I_ACK) && !berr_q);
   // dtack or berr low through the answer state
   // answer kept one more cycle, after data is released
   assign bus.i_dtack_o = 1'b0;
   assign bus.i_dtack_oe_n = !((state == I_ACK || state == I_DREL) && !berr_q);
   assign bus.i_berr_o = 1'b0;
   assign bus.i_berr_oe_n = !((state == I_ACK || state == I_DREL) && berr_q);
endmodule : bia_interrupter

// ### verif/bia_properties.sv
// Purpose: concurrent checks on the acknowledge cycle wires
// Assumes: both ends joined through one interface on one clock
// Notes: intervals are the package cycle counts
`timescale 1ns/1ps
module bia_properties
   import bia_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // handler lines
   input wire logic [CTL_W-1:0] h_ctl_oe_n,
   input wire logic [CTL_W-1:0] ctl,
   // interrupter lines
   input wire logic dtack_n,
   input wire logic berr_n,
   input wire logic i_d_oe_n
);
   // delay bounds as local constants
   localparam int DSB_LIM = C_DSB_MAX;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // named views of the control lines
   logic as_l, dsa, dsb, wr, iack, quiet;
   assign as_l = ctl[CTL_AS];
   assign dsa = ctl[CTL_DS0];
   assign dsb = ctl[CTL_DS1];
   assign wr = ctl[CTL_WR];
   assign iack = ctl[CTL_IACK];
   assign quiet = dtack_n && berr_n;
   // answer seen since as fell, cleared while as is high
   logic answered;
   always_ff @(posedge clock) begin
      if (reset || as_l) begin
         answered <= 1'b0;
      end else if (!quiet) begin
         answered <= 1'b1;
      end
   end
   as_gap_a: assert property ($fell(as_l) |-> $past(as_l, 2) && $past(as_l, 3))
      else $error("as low again too soon");
   as_setup_a: assert property ($fell(as_l) |-> !$past(iack, 4) && $past(ctl[8:4], 4) == ctl[8:4])
      else $error("code not set up before as");
   dsa_order_a: assert property ($fell(dsa) |-> !as_l && quiet)
      else $error("first strobe before as or with answer low");
   strobe_idle_a: assert property ($fell(dsa) |-> $past(dsb, 4) && $past(wr, 4) && $past(dsa) && $past(dsb) && $past(wr))
      else $error("strobes or write not high long enough");
   second_strobe_a: assert property ($fell(dsa) && !ctl[CTL_LW] |-> ##[0:DSB_LIM] !dsb)
      else $error("second strobe late");
   code_held_a: assert property (!as_l && !$past(as_l) && !answered |-> !iack && $stable(ctl[8:5]))
      else $error("code changed before answer");
   as_low_min_a: assert property ($fell(as_l) |-> !as_l [*4])
      else $error("as low too short");
   strobe_held_a: assert property (!answered |-> (ctl[2:1] & ~$past(ctl[2:1])) == 2'h0)
      else $error("strobe rose before answer");
   write_hold_a: assert property ($rose(dsa) |-> (wr && !h_ctl_oe_n[CTL_WR]) [*2])
      else $error("write not held after strobes");
   release_first_a: assert property ($rose(as_l) |-> &h_ctl_oe_n[CTL_W-1:1])
      else $error("lines driven as as rises");
   ack_wait_a: assert property ($fell(dsa) |-> quiet [*3])
      else $error("answer too soon after strobe");
   data_release_a: assert property ($rose(dtack_n) |-> $past(i_d_oe_n))
      else $error("data still driven at answer release");
endmodule : bia_properties

// ### verif/test_backplane_interrupt_ack_cycle.sv
// Purpose: self-checking bench for both ends of the acknowledge cycle
// Assumes: the requester grants the bus one cycle after it is wanted
// Notes: a queue model predicts every answer from random fields
`timescale 1ns/1ps
module test_backplane_interrupt_ack_cycle;
   import bia_pkg::*;
   // clock, reset and handler user side
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic bus_granted = 1'b0;
   logic start = 1'b0;
   logic [CODE_W-1:0] level = 3'h1;
   bia_size_t size = BIA_SZ_SINGLE;
   logic wants_bus, busy, done, bus_error, ack_taken;
   logic [DATA_W-1:0] status_id;
   bia_size_t ack_size;
   // interrupter user side
   logic [CODE_W-1:0] irq_level = 3'h1;
   logic [DATA_W-1:0] sid = 32'h0;
   logic answer_berr = 1'b0;
   // model state
   int fail_count = 0;
   int checks = 0;
   logic [31:0] seed = 32'h38;
   logic [DATA_W-1:0] want_q[$];
   logic err_q[$];
   logic [4:0] exp_ctl;
   bia_size_t exp_size;
   int k;
   logic [31:0] r;
   bia_if bus ();
   bia_handler i_bia_handler (.clock(clock), .reset(reset), .wants_bus(wants_bus),
      .bus_granted(bus_granted), .start(start), .level(level), .size(size), .busy(busy),
      .done(done), .bus_error(bus_error), .status_id(status_id), .bus(bus));
   bia_interrupter i_bia_interrupter (.clock(clock), .reset(reset), .irq_level(irq_level),
      .status_id(sid), .answer_berr(answer_berr), .ack_taken(ack_taken),
      .ack_size(ack_size), .bus(bus));
   bia_properties i_bia_properties (.clock(clock), .reset(reset), .h_ctl_oe_n(bus.h_ctl_oe_n),
      .ctl(bus.ctl), .dtack_n(bus.dtack_n), .berr_n(bus.berr_n), .i_d_oe_n(bus.i_d_oe_n));
   // clock and a requester that grants after one cycle
   always #5 clock = ~clock;
   always @(posedge clock) bus_granted <= wants_bus;
   // xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // count and report one comparison
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want,
      input string what);
      checks++;
      if (seen !== want) begin
         fail_count++;
         $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask : check
   // counts, verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   // bounded wait: 0 done, 1 iack line, 2 daisy output
   task automatic wait_on(input int what, input logic lvl);
      int n;
      for (n = 0; n < 400; n++) begin
         if ((what == 0 ? done : what == 1 ? bus.ctl[CTL_IACK] : bus.iackout_n) === lvl) break;
         @(posedge clock);
      end
      if (n == 400) begin
         fail_count++;
         $display("BAD %0t wait %0d ran out", $time, what);
         final_report();
      end
   endtask : wait_on
   // interrupter width and the code still on the wire as it answers
   always @(posedge clock) begin
      if (ack_taken === 1'b1) begin
         if (answer_berr === 1'b0) check(32'(ack_size), 32'(exp_size), "width");
         check(32'(bus.ctl[8:4]), 32'(exp_ctl), "code on wire");
      end
   end
   // one acknowledge cycle, start held until the cycle is set up
   task automatic run_cycle(input logic [2:0] lvl, input logic [1:0] sz, input logic err);
      logic [DATA_W-1:0] mask;
      logic [DATA_W-1:0] v;
      mask = (sz == 2'h0) ? 32'hff : (sz == 2'h1) ? 32'hffff : 32'hffffffff;
      v = rnd();
      wait_on(1, 1'b1);
      level <= lvl;
      size <= bia_size_t'(sz);
      irq_level <= lvl;
      sid <= v;
      answer_berr <= err;
      start <= 1'b1;
      exp_size = bia_size_t'(sz);
      exp_ctl = {lvl, sz != 2'h2, 1'b0};
      want_q.push_back(v & mask);
      err_q.push_back(err);
      @(posedge clock);
      wait_on(1, 1'b0);
      start <= 1'b0;
      wait_on(0, 1'b1);
      v = want_q.pop_front();
      check(32'(bus_error), 32'(err_q[0]), "error flag");
      if (err_q.pop_front() == 1'b0) check(status_id & mask, v, "status id");
      @(posedge clock);
   endtask : run_cycle
   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      // every width, then back-to-back random cycles with some bus errors
      for (k = 0; k < 3; k++) run_cycle(3'(k + 1), 2'(k), 1'b0);
      repeat (20) @(posedge clock);
      for (k = 0; k < 14; k++) begin
         r = rnd();
         run_cycle((r[2:0] == 3'h0) ? 3'h7 : r[2:0], 2'(r[4:3] % 3), r[7:5] == 3'h0);
      end
      $display("test cycles done");
      // no matching level: acknowledge passed on, then reset mid-cycle
      for (k = 0; k < 2; k++) begin
         // let the previous cycle drop iack before a new request
         wait_on(1, 1'b1);
         irq_level <= (k == 0) ? 3'h0 : 3'h2;
         level <= 3'h5;
         start <= 1'b1;
         wait_on(1, 1'b0);
         start <= 1'b0;
         wait_on(2, 1'b0);
         check(32'(bus.i_d_oe_n), 32'h1, "data quiet");
         reset <= 1'b1;
         repeat (3) @(posedge clock);
         reset <= 1'b0;
         check(32'(bus.h_ctl_oe_n), 32'h1ff, "released");
         check(32'(wants_bus), 32'h0, "bus not wanted");
         check(32'(busy), 32'h0, "idle after reset");
         @(posedge clock);
      end
      $display("test pass-on done");
      run_cycle(3'h3, 2'h2, 1'b0);
      $display("test recovery done");
      final_report();
   end
endmodule : test_backplane_interrupt_ack_cycle
